/* File: core/fault_status_register_bank.sv */
// Read-and-clear fault status registers with transceiver fault handling.
// Assumes event inputs are core_clk pulses from on-chip monitors; pin
// inputs (serial port, transmit data) are asynchronous and synchronised.
`timescale 1ns/1ps
`default_nettype none
`include "fault_status_consts.svh"

module fault_status_register_bank
	import fault_status_pkg::*;
#(
	parameter int TX_ENABLE_CYCLES = `TX_ENABLE_CYCLES
)(
	// Clock and reset
	input  wire logic       core_clk,
	input  wire logic       nrst,
	// Serial pins
	input  wire logic       spiCsN,
	input  wire logic       spiClk,
	input  wire logic       spiDi,
	output logic            spiDo,
	output logic            spiDoOe,
	// Thermal monitors
	input  wire logic       prewarnEvent,
	input  wire logic       tsdStageOneEvent,
	input  wire logic       tsdStageTwoEvent,
	// Supervisor events
	input  wire logic       restartEntry,
	input  wire logic       watchdogFailEvent,
	input  wire logic       watchdogTriggerOk,
	input  wire logic       mainUndervoltageEvent,
	input  wire logic       mainOvervoltageEvent,
	input  wire logic       mainOvervoltageRestartEn,
	input  wire logic       sleepWakeEvent,
	input  wire logic       failsafeWakeEvent,
	input  wire logic       resetPinStuckHigh,
	input  wire logic       failsafeInputPatternError,
	input  wire logic       failOutputsActive,
	// Transceivers, index 0 is LIN, index 1 is CAN
	input  wire logic [1:0] linMode,
	input  wire logic [1:0] canMode,
	input  wire logic [1:0] txdPin,
	input  wire logic [1:0] xcvrThermal,
	input  wire logic [1:0] txdTimeoutEvent,
	input  wire logic [1:0] busDominantEvent,
	input  wire logic [1:0] busRecessive,
	input  wire logic       canSupplyLow,
	input  wire logic       canWakePatternSeen,
	// Status outputs
	output logic            failsafeModeRequest,
	output logic      [1:0] txEnable,
	output logic      [1:0] watchdogFailureCount
);

	logic [6:0]        frameAddr;
	logic              frameClear, frameDone, frameOk;
	logic [7:0]        readData;
	logic [2:0]        thermFlags, next_thermFlags;
	logic [7:0]        devFlags, next_devFlags;
	fault_code_t       linCode, next_linCode, canCode, next_canCode;
	logic              canUvFlag, next_canUvFlag, next_failsafeModeRequest;
	logic [1:0]        txdS1, txdS2;
	logic [1:0]        thermPrev;
	fault_code_t       eventCode [2];
	xcvr_mode_t        modeOf [2];
	logic              uvComparatorOn, uvNow;
	logic              thermClear, devClear, busClear, failureEvent;

	spi_frame_port u_port (
		.core_clk   (core_clk),
		.nrst       (nrst),
		.spiCsN     (spiCsN),
		.spiClk     (spiClk),
		.spiDi      (spiDi),
		.spiDo      (spiDo),
		.spiDoOe    (spiDoOe),
		.readData   (readData),
		.frameAddr  (frameAddr),
		.frameClear (frameClear),
		.frameDone  (frameDone),
		.frameOk    (frameOk)
	);

	assign thermClear = frameDone && frameOk && frameClear && (frameAddr == `ADDR_THERMAL_FLAGS);
	assign devClear   = frameDone && frameOk && frameClear && (frameAddr == `ADDR_DEVICE_HISTORY);
	assign busClear   = frameDone && frameOk && frameClear && (frameAddr == `ADDR_BUS_FAULT_FIRST);

	// upper thermal bits forced to zero
	always_comb begin
		unique case (frameAddr)
			`ADDR_THERMAL_FLAGS:   readData = {5'h00, thermFlags};
			`ADDR_DEVICE_HISTORY:  readData = devFlags;
			`ADDR_BUS_FAULT_FIRST: readData = {1'b0, linCode, 2'b00, canCode, canUvFlag};
			default:               readData = `RESET_BYTE;
		endcase
	end

	assign modeOf[0] = xcvr_mode_t'(linMode);
	assign modeOf[1] = xcvr_mode_t'(canMode);

	assign uvComparatorOn = (modeOf[1] == XCVR_NORMAL) || (modeOf[1] == XCVR_RX_ONLY) ||
		((modeOf[1] == XCVR_WAKE) && canWakePatternSeen);
	// undervoltage lasts only while supply is low
	assign uvNow = uvComparatorOn && canSupplyLow;

	// failure causes, overvoltage only when enabled
	assign failureEvent = watchdogFailEvent || tsdStageTwoEvent || mainUndervoltageEvent ||
		(mainOvervoltageEvent && mainOvervoltageRestartEn);

	// Per-transceiver fault tracking and transmitter release
	genvar g;
	generate
		for (g = 0; g < 2; g++) begin : gen_xcvr
			logic      txdHeld, next_txdHeld, busHeld, next_busHeld, faultNow;
			tx_state_t txState, next_txState;
			logic [15:0] settleCount, next_settleCount;
			logic      quiet;

			// Wake-capable or off also ends the timeouts
			assign quiet = (modeOf[g] == XCVR_WAKE) || (modeOf[g] == XCVR_OFF);
			assign faultNow = xcvrThermal[g] || txdHeld || busHeld || ((g == 1) && uvNow);
			assign eventCode[g] = (xcvrThermal[g] && !thermPrev[g]) ? FAULT_THERMAL :
				busDominantEvent[g] ? FAULT_BUS_DOM :
				txdTimeoutEvent[g] ? FAULT_TXD_DOM : FAULT_NONE;

			always_comb begin
				next_txdHeld     = txdHeld;
				next_busHeld     = busHeld;
				next_txState     = txState;
				next_settleCount = settleCount;
				if (txdTimeoutEvent[g]) begin
					next_txdHeld = 1'b1;
				end else if (txdS2[g] || quiet) begin
					next_txdHeld = 1'b0;
				end
				if (busDominantEvent[g]) begin
					next_busHeld = 1'b1;
				end else if (busRecessive[g] || quiet) begin
					next_busHeld = 1'b0;
				end
				unique case (txState)
					TX_RUN: begin
						if (faultNow) begin
							next_txState = TX_BLOCKED;
						end
					end
					TX_BLOCKED: begin
						next_settleCount = 16'h0000;
						if (!faultNow) begin
							next_txState = TX_SETTLE;
						end
					end
					TX_SETTLE: begin
						if (faultNow) begin
							next_txState = TX_BLOCKED;
						end else if (!txdS2[g]) begin
							next_settleCount = 16'h0000;
						end else if (settleCount == 16'(TX_ENABLE_CYCLES - 1)) begin
							next_txState = TX_RUN;
						end else begin
							next_settleCount = settleCount + 16'h0001;
						end
					end
					default: next_txState = TX_BLOCKED;
				endcase
			end

			always_ff @(posedge core_clk) begin
				if (!nrst) begin
					txdHeld     <= 1'b0;
					busHeld     <= 1'b0;
					txState     <= TX_SETTLE;
					settleCount <= 16'h0000;
				end else begin
					txdHeld     <= next_txdHeld;
					busHeld     <= next_busHeld;
					txState     <= next_txState;
					settleCount <= next_settleCount;
				end
			end

			assign txEnable[g] = (txState == TX_RUN) && !faultNow;
		end
	endgenerate

	// Status registers: clear first, then sets, so a set wins
	always_comb begin
		next_thermFlags = thermFlags;
		next_devFlags   = devFlags;
		next_linCode    = linCode;
		next_canCode    = canCode;
		next_canUvFlag  = canUvFlag;
		if (thermClear) begin
			next_thermFlags = `RESET_THERMAL_FLAGS;
		end
		if (devClear) begin
			next_devFlags = {2'b00, 2'b00, devFlags[3:2], 2'b00};
		end
		if (busClear) begin
			next_linCode   = FAULT_NONE;
			next_canCode   = FAULT_NONE;
			next_canUvFlag = 1'b0;
		end
		if (tsdStageTwoEvent) next_thermFlags[`BIT_SHUTDOWN_TWO] = 1'b1;
		if (tsdStageOneEvent || eventCode[0] == FAULT_THERMAL || eventCode[1] == FAULT_THERMAL) begin
			next_thermFlags[`BIT_SHUTDOWN_ONE] = 1'b1;
		end
		if (prewarnEvent) next_thermFlags[`BIT_PREWARNING] = 1'b1;
		// restart cause, failure ranks above sleep wake
		if (failureEvent || failsafeWakeEvent) begin
			next_devFlags[7:6] = CAUSE_FAILURE;
		end else if (sleepWakeEvent) begin
			next_devFlags[7:6] = CAUSE_SLEEP;
		end
		if (resetPinStuckHigh) next_devFlags[`BIT_RESET_STUCK_HIGH] = 1'b1;
		if (failsafeInputPatternError) next_devFlags[`BIT_FAILSAFE_PATTERN] = 1'b1;
		if (watchdogTriggerOk) begin
			next_devFlags[3:2] = 2'b00;
		end else if (watchdogFailEvent && devFlags[3:2] != `WATCHDOG_COUNT_MAX) begin
			next_devFlags[3:2] = devFlags[3:2] + 2'b01;
		end
		// invalid frame flagged, only host clears
		if (frameDone && !frameOk) next_devFlags[`BIT_INVALID_COMMAND] = 1'b1;
		if (failOutputsActive) next_devFlags[`BIT_FAIL_OUTPUTS] = 1'b1;
		if (eventCode[0] != FAULT_NONE) next_linCode = eventCode[0];
		if (eventCode[1] != FAULT_NONE) next_canCode = eventCode[1];
		if (uvNow) next_canUvFlag = 1'b1;
		next_failsafeModeRequest = tsdStageTwoEvent;
	end

	// reset clears flags, codes and request, presets transmit data sync to ones; restart keeps stored flags
	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			thermFlags          <= `RESET_THERMAL_FLAGS;
			devFlags            <= `RESET_BYTE;
			linCode             <= FAULT_NONE;
			canCode             <= FAULT_NONE;
			canUvFlag           <= 1'b0;
			failsafeModeRequest <= 1'b0;
			txdS1               <= 2'b11;
			txdS2               <= 2'b11;
			thermPrev           <= 2'b00;
		end else begin
			thermFlags          <= next_thermFlags;
			devFlags            <= next_devFlags;
			linCode             <= next_linCode;
			canCode             <= next_canCode;
			canUvFlag           <= next_canUvFlag;
			failsafeModeRequest <= next_failsafeModeRequest;
			txdS1               <= txdPin;
			txdS2               <= txdS1;
			thermPrev           <= xcvrThermal;
		end
	end

	assign watchdogFailureCount = devFlags[3:2];

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!nrst);

	AST_THERM_RESERVED: assert property (
		(frameAddr == `ADDR_THERMAL_FLAGS) |-> (readData[7:3] == 5'h00))
		else $error("thermal reserved bits not zero");
	AST_THERMAL_SHUTDOWN_STAGE_TWO_FAILSAFE: assert property (
		tsdStageTwoEvent |=> (thermFlags[2] && failsafeModeRequest))
		else $error("stage two shutdown not latched with fail-safe request");
	AST_THERMAL_SHUTDOWN_STAGE_ONE_HOLDS: assert property (
		(thermFlags[1] && !thermClear) |=> thermFlags[1])
		else $error("stage one flag lost without clear");
	AST_PREWARN_SET: assert property (
		prewarnEvent |=> thermFlags[0])
		else $error("prewarning not latched");
	AST_WD_NEVER_THREE: assert property (
		watchdogFailureCount != 2'b11)
		else $error("watchdog counter reached three");
	AST_WD_SELF_CLEAR: assert property (
		(watchdogTriggerOk ##1 !watchdogFailEvent) |-> (watchdogFailureCount == 2'b00))
		else $error("watchdog counter not cleared by good trigger");
	AST_INVALID_FRAME: assert property (
		(frameDone && !frameOk) |=> devFlags[1])
		else $error("invalid frame not flagged");
	AST_INVALID_KEEP: assert property (
		(devFlags[1] && !devClear) |=> devFlags[1])
		else $error("invalid command flag dropped without host clear");
	AST_UV_TX_OFF: assert property (
		uvNow |-> (!txEnable[1] ##1 canUvFlag))
		else $error("CAN transmitter enabled during undervoltage");
	AST_SET_WINS: assert property (
		(devClear && resetPinStuckHigh) |=> devFlags[5])
		else $error("set lost against clear");

endmodule
`default_nettype wire

/* File: core/fault_status_consts.svh */
// Register offsets, field positions, reset values and timing figures
// for the fault status register bank. Definitions only.
`ifndef FAULT_STATUS_CONSTS_SVH
`define FAULT_STATUS_CONSTS_SVH

// Register addresses, 7-bit serial address space
`define ADDR_THERMAL_FLAGS      7'h42
`define ADDR_DEVICE_HISTORY     7'h43
`define ADDR_BUS_FAULT_FIRST    7'h44

// Reset values after power-on or soft reset
`define RESET_THERMAL_FLAGS     3'h0
`define RESET_BYTE              8'h00

// Thermal flag positions
`define BIT_PREWARNING          0
`define BIT_SHUTDOWN_ONE        1
`define BIT_SHUTDOWN_TWO        2

// Device history field positions
`define BIT_FAIL_OUTPUTS        0
`define BIT_INVALID_COMMAND     1
`define BIT_FAILSAFE_PATTERN    4
`define BIT_RESET_STUCK_HIGH    5

// Watchdog failure counter ceiling, code 3 is never reached
`define WATCHDOG_COUNT_MAX      2'h2

// Serial frame shape
`define FRAME_BITS              5'h10
`define ADDRESS_BITS            5'h08

// Transmitter enable time and core clock period in ns
`define TX_ENABLE_TIME_NS       10000
`define CORE_CLK_PERIOD_NS      25
`define TX_ENABLE_CYCLES        ((`TX_ENABLE_TIME_NS + `CORE_CLK_PERIOD_NS - 1) / `CORE_CLK_PERIOD_NS)

`endif

/* File: core/fault_status_pkg.sv */
// Types shared by the fault status register bank and its serial port.
// Assumes the constants header is compiled alongside.
package fault_status_pkg;

	// Transceiver operating mode as seen from the mode controller
	typedef enum logic [1:0] {
		XCVR_OFF     = 2'b00,
		XCVR_NORMAL  = 2'b01,
		XCVR_RX_ONLY = 2'b10,
		XCVR_WAKE    = 2'b11
	} xcvr_mode_t;

	// Transceiver fault code as stored in the bus fault register
	typedef enum logic [1:0] {
		FAULT_NONE    = 2'b00,
		FAULT_THERMAL = 2'b01,
		FAULT_TXD_DOM = 2'b10,
		FAULT_BUS_DOM = 2'b11
	} fault_code_t;

	// Cause of the last restart
	typedef enum logic [1:0] {
		CAUSE_CLEARED = 2'b00,
		CAUSE_FAILURE = 2'b01,
		CAUSE_SLEEP   = 2'b10,
		CAUSE_UNUSED  = 2'b11
	} restart_cause_t;

	// Transmitter path state
	typedef enum logic [1:0] {
		TX_RUN     = 2'b00,
		TX_BLOCKED = 2'b01,
		TX_SETTLE  = 2'b10
	} tx_state_t;

endpackage

/* File: core/spi_frame_port.sv */
// Serial slave for 16-bit frames: address in bits 0..6, access mode in
// bit 7, data in bits 8..15, least significant bit first.
// Assumes clock idles low; data sampled on rising, driven on falling edge.
// All input pins are asynchronous to core_clk and are synchronised here.
`timescale 1ns/1ps
`default_nettype none
`include "fault_status_consts.svh"

module spi_frame_port
	import fault_status_pkg::*;
(
	// Core clock and reset
	input  wire logic       core_clk,
	input  wire logic       nrst,
	// Serial pins
	input  wire logic       spiCsN,
	input  wire logic       spiClk,
	input  wire logic       spiDi,
	output logic            spiDo,
	output logic            spiDoOe,
	// Register side
	input  wire logic [7:0] readData,
	output logic      [6:0] frameAddr,
	output logic            frameClear,
	output logic            frameDone,
	output logic            frameOk
);

	logic       csnS1, csnS2, csnS3, clkS1, clkS2, clkS3, diS1, diS2;
	logic [7:0] shiftIn, next_shiftIn, shiftOut, next_shiftOut;
	logic [4:0] bitCount, next_bitCount;
	logic [6:0] next_frameAddr;
	logic       next_frameClear, loadPending, next_loadPending, doReg, next_doReg;
	logic       sclkRise, sclkFall, frameStart, frameEnd;

	// Edge detection on second and third stages only
	assign sclkRise   = clkS2 & ~clkS3 & ~csnS2;
	assign sclkFall   = ~clkS2 & clkS3 & ~csnS2;
	assign frameStart = ~csnS2 & csnS3;
	assign frameEnd   = csnS2 & ~csnS3;

	// Shift, count and answer path
	always_comb begin
		next_shiftIn     = shiftIn;
		next_shiftOut    = shiftOut;
		next_bitCount    = bitCount;
		next_frameAddr   = frameAddr;
		next_frameClear  = frameClear;
		next_loadPending = 1'b0;
		next_doReg       = doReg;
		if (frameStart) begin
			next_bitCount = 5'h00;
			next_doReg    = 1'b0;
		end
		if (sclkRise) begin
			next_shiftIn = {diS2, shiftIn[7:1]};
			if (bitCount != 5'h1F) begin
				next_bitCount = bitCount + 5'h01;
			end
			// Address complete after eighth bit
			if (bitCount == `ADDRESS_BITS - 5'h01) begin
				next_frameAddr   = shiftIn[7:1];
				next_frameClear  = diS2;
				next_loadPending = 1'b1;
			end
		end
		// Register mux settles one cycle after the address
		if (loadPending) begin
			next_shiftOut = readData;
		end
		if (sclkFall) begin
			if (bitCount >= `ADDRESS_BITS) begin
				next_doReg    = shiftOut[0];
				next_shiftOut = {1'b0, shiftOut[7:1]};
			end else begin
				next_doReg = 1'b0;
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			csnS1      <= 1'b1;
			csnS2      <= 1'b1;
			csnS3      <= 1'b1;
			clkS1      <= 1'b0;
			clkS2      <= 1'b0;
			clkS3      <= 1'b0;
			diS1       <= 1'b0;
			diS2       <= 1'b0;
			shiftIn    <= `RESET_BYTE;
			shiftOut   <= `RESET_BYTE;
			bitCount   <= 5'h00;
			frameAddr  <= 7'h00;
			frameClear <= 1'b0;
			loadPending <= 1'b0;
			doReg      <= 1'b0;
			frameDone  <= 1'b0;
			frameOk    <= 1'b0;
		end else begin
			csnS1      <= spiCsN;
			csnS2      <= csnS1;
			csnS3      <= csnS2;
			clkS1      <= spiClk;
			clkS2      <= clkS1;
			clkS3      <= clkS2;
			diS1       <= spiDi;
			diS2       <= diS1;
			shiftIn    <= next_shiftIn;
			shiftOut   <= next_shiftOut;
			bitCount   <= next_bitCount;
			frameAddr  <= next_frameAddr;
			frameClear <= next_frameClear;
			loadPending <= next_loadPending;
			doReg      <= next_doReg;
			frameDone  <= frameEnd;
			frameOk    <= frameEnd && (bitCount == `FRAME_BITS);
		end
	end

	// Pin driven only while selected
	assign spiDo   = doReg;
	assign spiDoOe = ~csnS2;

endmodule
`default_nettype wire

/* File: verif/spi_host_model.sv */
// Host side serial master: 16-bit frames, LSB first, clock idles low.
// Assumes the bench calls xfer from one process, never overlapping.
`timescale 1ns/1ps
`default_nettype none

module spi_host_model (
	// Serial pins
	output logic      spiCsN,
	output logic      spiClk,
	output logic      spiDi,
	input  wire logic spiDo
);
	// Idle bus: deselected, clock parked low
	initial begin
		spiCsN = 1'b1;
		spiClk = 1'b0;
		spiDi  = 1'b0;
	end

	task automatic xfer(input logic [6:0] a, input logic clr, input int n,
		output logic [7:0] d);
		logic [15:0] f;
		f = {8'hA5, clr, a};
		d = 8'h00;
		spiCsN = 1'b0;
		#100;
		for (int k = 0; k < n; k++) begin
			spiDi = f[k];
			#100 spiClk = 1'b1;
			if (k >= 8) d[k-8] = spiDo;
			#100 spiClk = 1'b0;
		end
		#100 spiCsN = 1'b1;
		// Stale bit inverted so a late sample cannot pass
		spiDi = ~spiDi;
		#300;
	endtask
endmodule

`default_nettype wire

/* File: verif/testbench.sv */
// Self-checking bench for the fault status register bank.
// Assumes the host model drives the serial pins and TX_ENABLE_CYCLES is 8.
`timescale 1ns/1ps
`default_nettype none

module testbench;
	logic        core_clk;
	logic        nrst;
	wire         spiCsN;
	wire         spiClk;
	wire         spiDi;
	wire         spiDo;
	wire         spiDoOe;
	logic [16:0] ev;
	logic        ovEn;
	logic [1:0]  linMode;
	logic [1:0]  canMode;
	logic [1:0]  txd;
	logic [1:0]  xth;
	logic [1:0]  busRec;
	logic        canLow;
	logic        wake_up_pattern;
	wire         failsafeModeRequest;
	wire  [1:0]  txEnable;
	wire  [1:0]  watchdogFailureCount;
	logic [7:0]  th;
	logic [7:0]  dh;
	logic [7:0]  bs;
	logic [1:0]  cnt;
	logic [7:0]  rdat;
	logic [7:0]  m;
	int          miscompares;
	int          checked;

	fault_status_register_bank #(.TX_ENABLE_CYCLES(8)) dut (
		.core_clk, .nrst, .spiCsN, .spiClk, .spiDi, .spiDo, .spiDoOe,
		.prewarnEvent(ev[0]), .tsdStageOneEvent(ev[1]), .tsdStageTwoEvent(ev[2]),
		.watchdogFailEvent(ev[3]), .watchdogTriggerOk(ev[4]),
		.mainUndervoltageEvent(ev[5]), .mainOvervoltageEvent(ev[6]),
		.sleepWakeEvent(ev[7]), .failsafeWakeEvent(ev[8]),
		.resetPinStuckHigh(ev[9]), .failsafeInputPatternError(ev[10]),
		.failOutputsActive(ev[11]), .restartEntry(ev[12]),
		.txdTimeoutEvent(ev[14:13]), .busDominantEvent(ev[16:15]),
		.mainOvervoltageRestartEn(ovEn), .linMode, .canMode, .txdPin(txd),
		.xcvrThermal(xth), .busRecessive(busRec), .canSupplyLow(canLow),
		.canWakePatternSeen(wake_up_pattern), .failsafeModeRequest, .txEnable,
		.watchdogFailureCount
	);

	spi_host_model host (.spiCsN, .spiClk, .spiDi, .spiDo);

	// Core clock, 25 ns period
	always #12.5 core_clk = ~core_clk;

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checked++;
		if (got !== exp) begin
			miscompares++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask

	// Expected history byte; counter kept apart as clears skip it
	function automatic logic [7:0] hist();
		return {dh[7:6], dh[5:4], cnt, dh[1:0]};
	endfunction

	// One-cycle event pulse plus matching model update
	task automatic pulse(input int i);
		ev = '0;
		ev[i] = 1'b1;
		cyc(1);
		ev = '0;
		case (i)
			0: th[0] = 1'b1;
			1: th[1] = 1'b1;
			2: begin
				th[2] = 1'b1;
				dh[7:6] = 2'b01;
				chk(failsafeModeRequest, 1'b1);
			end
			3: begin
				if (cnt != 2'h2) cnt = cnt + 2'h1;
				dh[7:6] = 2'b01;
			end
			4: cnt = 2'h0;
			5, 8: dh[7:6] = 2'b01;
			6: if (ovEn) dh[7:6] = 2'b01;
			7: dh[7:6] = 2'b10;
			9: dh[5] = 1'b1;
			10: dh[4] = 1'b1;
			11: dh[0] = 1'b1;
			13: bs[6:5] = 2'b10;
			16: bs[2:1] = 2'b11;
			default: ;
		endcase
		cyc(1);
		chk(watchdogFailureCount, cnt);
	endtask

	task automatic rd(input logic [6:0] a, input logic [7:0] e);
		host.xfer(a, 1'b0, 16, rdat);
		cyc(1);
		chk(rdat, e);
		chk(spiDoOe, 1'b0);
	endtask

	task automatic clr(input logic [6:0] a);
		host.xfer(a, 1'b1, 16, rdat);
		cyc(1);
		if (a == 7'h42) th = 8'h00;
		if (a == 7'h43) dh = 8'h00;
		if (a == 7'h44) bs = 8'h00;
	endtask

	task automatic finish_test;
		$display("checked %0d, miscompares %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	// Hang guard, far beyond the expected run of about 140 us
	initial begin
		#1ms;
		miscompares++;
		finish_test();
	end

	// Main sequence
	initial begin
		core_clk = 1'b0;
		nrst = 1'b0;
		ev = '0;
		ovEn = 1'b0;
		linMode = 2'b01;
		canMode = 2'b01;
		txd = 2'b11;
		xth = 2'b00;
		busRec = 2'b11;
		canLow = 1'b0;
		wake_up_pattern = 1'b0;
		{th, dh, bs, cnt} = '0;
		miscompares = 0;
		checked = 0;
		m = 8'($urandom(98852));
		cyc(12);
		nrst = 1'b1;
		cyc(4);
		rd(7'h42, 8'h00);
		rd(7'h43, 8'h00);
		rd(7'h44, 8'h00);
		rd(7'h45, 8'h00);
		$display("reset test done");
		for (int k = 0; k < 4; k++) begin
			m = 8'($urandom % 8) | (8'h01 << (k % 3));
			for (int b = 0; b < 3; b++) if (m[b]) pulse(b);
			pulse(12);
			rd(7'h42, th);
			clr(7'h42);
			rd(7'h42, th);
		end
		$display("thermal test done");
		clr(7'h43);
		pulse(7);
		rd(7'h43, hist());
		clr(7'h43);
		pulse(6);
		rd(7'h43, hist());
		ovEn = 1'b1;
		pulse(6);
		ovEn = 1'b0;
		rd(7'h43, hist());
		clr(7'h43);
		foreach (m[b]) if (b < 6) pulse(b + 3);
		pulse(3);
		pulse(3);
		pulse(9);
		pulse(10);
		pulse(11);
		rd(7'h43, hist());
		clr(7'h43);
		rd(7'h43, hist());
		pulse(4);
		rd(7'h43, hist());
		$display("history test done");
		pulse(0);
		host.xfer(7'h42, 1'b1, 15, rdat);
		cyc(1);
		dh[1] = 1'b1;
		rd(7'h42, th);
		clr(7'h42);
		rd(7'h43, hist());
		clr(7'h43);
		rd(7'h43, hist());
		$display("invalid frame test done");
		canMode = 2'b00;
		canLow = 1'b1;
		cyc(6);
		// Wake mode only watches the supply once a wake pattern was seen
		canMode = 2'b11;
		cyc(6);
		wake_up_pattern = 1'b1;
		cyc(2);
		bs[0] = 1'b1;
		canLow = 1'b0;
		wake_up_pattern = 1'b0;
		canMode = 2'b01;
		rd(7'h44, bs);
		chk(txEnable, 2'b11);
		canLow = 1'b1;
		cyc(3);
		chk(txEnable[1], 1'b0);
		bs[0] = 1'b1;
		canLow = 1'b0;
		cyc(14);
		chk(txEnable, 2'b11);
		txd[0] = 1'b0;
		cyc(3);
		pulse(13);
		chk(txEnable[0], 1'b0);
		txd[0] = 1'b1;
		cyc(14);
		chk(txEnable[0], 1'b1);
		busRec[1] = 1'b0;
		pulse(16);
		chk(txEnable[1], 1'b0);
		busRec[1] = 1'b1;
		cyc(14);
		chk(txEnable[1], 1'b1);
		xth[0] = 1'b1;
		cyc(3);
		chk(txEnable[0], 1'b0);
		bs[6:5] = 2'b01;
		th[1] = 1'b1;
		xth[0] = 1'b0;
		cyc(14);
		chk(txEnable[0], 1'b1);
		rd(7'h44, bs);
		rd(7'h42, th);
		clr(7'h44);
		rd(7'h44, bs);
		$display("transceiver test done");
		finish_test();
	end
endmodule

`default_nettype wire
